// *** pvic_cfg.svh ***
// Constants for the prioritized vectored interrupt controller.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PVIC_CFG_SVH
`define PVIC_CFG_SVH
`define PVIC_NUM_SRC 154
`define PVIC_PRIO_BITS 3
`define PVIC_MAX_DEPTH 8
`define PVIC_ADDR_ENABLE 32'h0000_0000
`define PVIC_ADDR_PRIO 32'h0000_0400
`define PVIC_ADDR_PEND 32'h0000_0800
`define PVIC_ADDR_CTRL 32'h0000_0C00
`define PVIC_ADDR_VTOR 32'h0000_0C04
`define PVIC_ADDR_STAT 32'h0000_0C08
`define PVIC_ADDR_TRIG 32'h0000_0C0C
`define PVIC_REGION_MASK 32'hFFFF_FC00
`define PVIC_INDEX_MASK 32'h0000_03FC
`define PVIC_VTOR_ALIGN_BITS 10
`define PVIC_STACK_CYC 4
`define PVIC_FETCH_CYC 2
`define PVIC_TABLE_BASE 32'h0000_0000
`define PVIC_SRAM_BASE 32'h2000_0000
`endif

// *** pvic_pkg.sv ***
// Types shared by the interrupt controller files.
// Assumes pvic_cfg.svh for constants.
`include "pvic_cfg.svh"
package pvic_pkg;
  typedef logic [`PVIC_PRIO_BITS-1:0] pvic_prio_t;
  typedef struct packed {
    logic valid;
    pvic_prio_t prio;
    logic [7:0] id;
  } pvic_cand_t;
  typedef struct packed {
    logic req;
    logic [7:0] id;
    logic [31:0] vector;
  } pvic_entry_t;
  typedef enum logic [1:0] {
    PVIC_IDLE = 2'b00,
    PVIC_STACK = 2'b01,
    PVIC_FETCH = 2'b10,
    PVIC_RUN = 2'b11
  } pvic_state_t;
endpackage

// *** pvic_pick.sv ***
// Two-way priority comparison used by the arbitration tree.
// Assumes both candidates carry full priority values; group masking is applied only for preemption.
`timescale 1ns/10ps
`default_nettype none
module pvic_pick (
  input wire pvic_pkg::pvic_cand_t a_i,
  input wire pvic_pkg::pvic_cand_t b_i,
  output pvic_pkg::pvic_cand_t win_o
);
  // Lower value wins; a tie keeps a, which always has the smaller number
  wire take_b = b_i.valid && (!a_i.valid || (b_i.prio < a_i.prio));
  assign win_o = take_b ? b_i : a_i;
endmodule
`default_nettype wire

// *** pvic_core.sv ***
// Prioritized vectored interrupt controller with APB register access.
// Assumes sources are synchronous pulses or levels from peripherals
// on clock_i, and that the core acknowledges vector delivery and
// signals handler return with single-cycle pulses.
// Behaviour
// - Up to 154 sources are arbitrated over eight priority levels.
// - Each source has its own enable, and a global mask blocks delivery without touching them.
// - The handler address for the accepted source is given straight to the core.
// - Higher-priority pending work is taken first and preempts a lower-priority handler.
// - Software splits priority bits into preemption and sub-priority parts.
// - Equal preemption level never preempts; it is tail chained after return.
// - Among identical priorities the smaller source number wins.
// - Nesting depth is tracked and interrupt context ends whenever the depth returns to zero, even between tail-chained handlers.
// - Table in flash overlaps stacking with fetch; table in SRAM makes them sequential.
// - Priorities are 8-bit fields with only the upper 3 bits kept.
// - Smaller priority value means more urgent, 0 is most urgent.
// - With the global mask set only the non-maskable input interrupts the core.
`timescale 1ns/10ps
`default_nettype none
`include "pvic_cfg.svh"
module pvic_core #(
  parameter int NUM_SRC = `PVIC_NUM_SRC,
  parameter int DEPTH = `PVIC_MAX_DEPTH
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [NUM_SRC-1:0] irq_i,
  input wire logic nmi_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic entry_ack_i,
  input wire logic exit_i,
  output pvic_pkg::pvic_entry_t entry_o,
  output logic in_handler_o
);
  localparam int NP = 256;
  localparam int IW = 8;
  localparam int DW = $clog2(DEPTH + 1);
  logic [NUM_SRC-1:0] en_reg, pend_reg, irq_q_reg;
  logic [`PVIC_PRIO_BITS-1:0] prio_reg [NUM_SRC];
  logic [2:0] split_reg;
  logic gmask_reg;
  logic [31:0] vtor_reg;
  logic [DW-1:0] depth_reg;
  // One spare slot: the non-maskable entry may nest above a full stack
  logic [`PVIC_PRIO_BITS-1:0] act_prio [DEPTH+1];
  logic nmi_q_reg, nmi_pend_reg, nmi_act_reg;
  pvic_pkg::pvic_state_t st_reg;
  logic [2:0] cnt_reg;
  logic [IW-1:0] sel_id_reg;
  logic sel_nmi_reg;
  logic [31:0] prdata_reg;
  logic rdy_reg, err_reg;
  pvic_pkg::pvic_entry_t entry_reg;
  logic in_handler_reg;

  // APB decode: one word per source for enable, priority and pending
  wire acc = psel_i && penable_i && !rdy_reg;
  // Writes land at the edge where the master samples pready high
  wire wr = psel_i && penable_i && rdy_reg && pwrite_i;
  // Each region spans 256 words so that all sources are reachable
  wire [31:0] off = paddr_i & `PVIC_INDEX_MASK;
  wire [IW-1:0] idx = off[9:2];
  wire idx_ok = 32'(idx) < NUM_SRC;
  wire hit_en = (paddr_i & `PVIC_REGION_MASK) == `PVIC_ADDR_ENABLE;
  wire hit_pr = (paddr_i & `PVIC_REGION_MASK) == `PVIC_ADDR_PRIO;
  wire hit_pd = (paddr_i & `PVIC_REGION_MASK) == `PVIC_ADDR_PEND;
  wire hit_ct = paddr_i == `PVIC_ADDR_CTRL;
  wire hit_vt = paddr_i == `PVIC_ADDR_VTOR;
  wire hit_st = paddr_i == `PVIC_ADDR_STAT;
  wire hit_tg = paddr_i == `PVIC_ADDR_TRIG;
  wire hit_ok = ((hit_en || hit_pr || hit_pd) && idx_ok) || hit_ct || hit_vt || hit_st || hit_tg;

  // Preemption mask keeps only the group bits selected by the split
  wire [`PVIC_PRIO_BITS-1:0] grp_mask = `PVIC_PRIO_BITS'(3'b111 << split_reg);
  wire [`PVIC_PRIO_BITS-1:0] cur_prio = (depth_reg == '0) ? '0 : act_prio[depth_reg - 1'b1];

  // Arbitration tree over padded candidates
  pvic_pkg::pvic_cand_t node [2*NP-1];
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_leaf
      if (g < NUM_SRC) begin : g_src
        assign node[NP-1+g].valid = pend_reg[g] && en_reg[g];
        assign node[NP-1+g].prio = prio_reg[g];
        assign node[NP-1+g].id = IW'(g);
      end else begin : g_pad
        assign node[NP-1+g] = '0;
      end
    end
    for (g = 0; g < NP-1; g++) begin : g_tree
      pvic_pick u_pick (
        .a_i(node[2*g+1]),
        .b_i(node[2*g+2]),
        .win_o(node[g])
      );
    end
  endgenerate
  wire pvic_pkg::pvic_cand_t best = node[0];
  // Only a strictly lower group value preempts; ties wait for return
  wire can_preempt = (depth_reg == '0) ||
                     ((best.prio & grp_mask) < (cur_prio & grp_mask));
  wire take_irq = best.valid && !gmask_reg && can_preempt && depth_reg < DEPTH;
  wire take_nmi = nmi_pend_reg && !nmi_act_reg;
  // A return owns the idle cycle; pending must not clear unless the entry starts
  wire ret_now = exit_i && depth_reg != '0;
  wire acc_nmi = st_reg == pvic_pkg::PVIC_IDLE && !ret_now && take_nmi;
  wire acc_irq = st_reg == pvic_pkg::PVIC_IDLE && !ret_now && take_irq && !take_nmi;
  wire flash_tbl = vtor_reg < `PVIC_SRAM_BASE;
  wire [31:0] vec_addr = vtor_reg + {22'h0, sel_nmi_reg ? 8'h02 : sel_id_reg + 8'h10, 2'b00};

  // Register writes, pending capture and priority storage
  always_ff @(posedge clock_i) begin
    irq_q_reg <= sys_rst_i ? '0 : irq_i;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (sys_rst_i) begin
        en_reg[i] <= 1'b0;
        pend_reg[i] <= 1'b0;
        prio_reg[i] <= '0;
      end else begin
        if (wr && hit_en && idx == IW'(i)) en_reg[i] <= pwdata_i[0];
        if (wr && hit_pr && idx == IW'(i)) prio_reg[i] <= pwdata_i[7:5];
        // New rising edge wins over the acceptance clear
        if ((irq_i[i] && !irq_q_reg[i]) || (wr && hit_tg && pwdata_i[7:0] == IW'(i)) ||
            (wr && hit_pd && idx == IW'(i) && pwdata_i[0])) pend_reg[i] <= 1'b1;
        else if ((acc_irq && best.id == IW'(i)) ||
                 (wr && hit_pd && idx == IW'(i) && !pwdata_i[0])) pend_reg[i] <= 1'b0;
      end
    end
  end

  // Control registers; table base is forced onto a 1-kB boundary
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      split_reg <= '0;
      gmask_reg <= 1'b0;
      vtor_reg <= `PVIC_TABLE_BASE;
    end else begin
      if (wr && hit_ct) begin
        gmask_reg <= pwdata_i[0];
        split_reg <= pwdata_i[10:8];
      end
      if (wr && hit_vt) vtor_reg <= {pwdata_i[31:`PVIC_VTOR_ALIGN_BITS], 10'h000};
    end
  end

  // APB answer: access phase with one wait state, error on unmapped words
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdy_reg <= 1'b0;
      err_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      rdy_reg <= acc;
      err_reg <= acc && !hit_ok;
      prdata_reg <= !acc ? '0 :
        (hit_en && idx_ok) ? {31'h0, en_reg[idx]} :
        (hit_pr && idx_ok) ? {24'h0, prio_reg[idx], 5'h00} :
        (hit_pd && idx_ok) ? {31'h0, pend_reg[idx]} :
        hit_ct ? {21'h0, split_reg, 7'h00, gmask_reg} :
        hit_vt ? vtor_reg :
        hit_st ? {16'h0, sel_id_reg, 4'(depth_reg), 2'(st_reg), nmi_act_reg, 1'b0} : '0;
    end
  end

  // Non-maskable input latched on its rising edge
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      nmi_q_reg <= 1'b0;
      nmi_pend_reg <= 1'b0;
    end else begin
      nmi_q_reg <= nmi_i;
      if (nmi_i && !nmi_q_reg) nmi_pend_reg <= 1'b1;
      else if (acc_nmi) nmi_pend_reg <= 1'b0;
    end
  end

  // Entry sequencer: stack, fetch, deliver, and the nesting stack
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_reg <= pvic_pkg::PVIC_IDLE;
      cnt_reg <= '0;
      depth_reg <= '0;
      sel_id_reg <= '0;
      sel_nmi_reg <= 1'b0;
      nmi_act_reg <= 1'b0;
      entry_reg <= '0;
      for (int k = 0; k <= DEPTH; k++) act_prio[k] <= '0;
    end else begin
      case (st_reg)
        pvic_pkg::PVIC_IDLE: begin
          if (exit_i && depth_reg != '0) begin
            depth_reg <= depth_reg - 1'b1;
            if (nmi_act_reg && depth_reg == 1'b1) nmi_act_reg <= 1'b0;
          end else if (take_nmi || take_irq) begin
            sel_nmi_reg <= take_nmi;
            sel_id_reg <= best.id;
            // Flash table overlaps stacking with fetch
            cnt_reg <= 3'(`PVIC_STACK_CYC);
            st_reg <= pvic_pkg::PVIC_STACK;
          end
        end
        pvic_pkg::PVIC_STACK: begin
          if (cnt_reg > 3'h1) cnt_reg <= cnt_reg - 3'h1;
          else if (flash_tbl) st_reg <= pvic_pkg::PVIC_RUN;
          else begin
            cnt_reg <= 3'(`PVIC_FETCH_CYC);
            st_reg <= pvic_pkg::PVIC_FETCH;
          end
        end
        pvic_pkg::PVIC_FETCH: begin
          if (cnt_reg > 3'h1) cnt_reg <= cnt_reg - 3'h1;
          else st_reg <= pvic_pkg::PVIC_RUN;
        end
        pvic_pkg::PVIC_RUN: begin
          entry_reg.req <= 1'b1;
          entry_reg.id <= sel_nmi_reg ? 8'hFF : sel_id_reg;
          entry_reg.vector <= vec_addr;
          if (entry_reg.req && entry_ack_i) begin
            entry_reg.req <= 1'b0;
            act_prio[depth_reg] <= sel_nmi_reg ? '0 : prio_reg[sel_id_reg];
            if (sel_nmi_reg) nmi_act_reg <= 1'b1;
            depth_reg <= depth_reg + 1'b1;
            st_reg <= pvic_pkg::PVIC_IDLE;
          end
        end
        default: st_reg <= pvic_pkg::PVIC_IDLE;
      endcase
    end
  end

  // Context flag is registered so the output comes straight from a flop
  always_ff @(posedge clock_i) begin
    in_handler_reg <= sys_rst_i ? 1'b0 : (depth_reg != '0);
  end

  assign prdata_o = prdata_reg;
  assign pready_o = rdy_reg;
  assign pslverr_o = err_reg;
  assign entry_o = entry_reg;
  assign in_handler_o = in_handler_reg;

  chk_apb_one_wait: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    psel_i && penable_i && !pready_o |=> pready_o)
    else $error("APB answer late");
  chk_mask_blocks: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    st_reg == pvic_pkg::PVIC_IDLE && gmask_reg && !take_nmi && !exit_i |=>
    st_reg == pvic_pkg::PVIC_IDLE)
    else $error("Entry while globally masked");
  chk_no_equal_preempt: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    st_reg == pvic_pkg::PVIC_IDLE && depth_reg != '0 && !exit_i && !take_nmi &&
    (best.prio & grp_mask) >= (cur_prio & grp_mask) |=> st_reg == pvic_pkg::PVIC_IDLE)
    else $error("Equal group preempted");
  chk_flash_latency: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(st_reg == pvic_pkg::PVIC_STACK) && flash_tbl |-> ##4 st_reg == pvic_pkg::PVIC_RUN)
    else $error("Flash table entry latency wrong");
  chk_sram_latency: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(st_reg == pvic_pkg::PVIC_STACK) && !flash_tbl && !(wr && hit_vt) |->
    ##[5:6] st_reg == pvic_pkg::PVIC_RUN)
    else $error("SRAM table entry latency wrong");
  chk_vector_addr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(entry_o.req) |-> entry_o.vector[9:0] ==
    (sel_nmi_reg ? 10'h008 : {sel_id_reg + 8'h10, 2'b00}))
    else $error("Vector address mismatch");
  chk_depth_step: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    entry_o.req && entry_ack_i |=> depth_reg == $past(depth_reg) + 1'b1)
    else $error("Nesting depth not raised");
  chk_pend_clear: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    st_reg == pvic_pkg::PVIC_IDLE && take_irq && !take_nmi && !exit_i && !irq_i[best.id]
    && !wr |=> !pend_reg[$past(best.id)])
    else $error("Pending not cleared on accept");
endmodule
`default_nettype wire

// *** pvic_cpu_model.sv ***
// Behavioural processor core facing the controller's vector port.
// Assumes entry_i.req stays high until the ack pulse is seen.
`timescale 1ns/10ps
`default_nettype none
module pvic_cpu_model (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire pvic_pkg::pvic_entry_t entry_i,
  input wire logic [3:0] ack_dly_i,
  input wire logic ret_i,
  output logic entry_ack_o,
  output logic exit_o,
  output logic taken_o,
  output logic [7:0] taken_id_o,
  output logic [31:0] taken_vec_o
);
  logic [3:0] wait_reg;
  // Accept a vector after a programmable stall; a slow core tests the held request
  always_ff @(posedge clock_i) begin
    entry_ack_o <= 1'b0;
    taken_o <= 1'b0;
    exit_o <= ret_i;
    if (sys_rst_i) begin
      wait_reg <= 4'h0;
      exit_o <= 1'b0;
    end else if (entry_i.req && !entry_ack_o) begin
      if (wait_reg >= ack_dly_i) begin
        entry_ack_o <= 1'b1;
        taken_o <= 1'b1;
        taken_id_o <= entry_i.id;
        taken_vec_o <= entry_i.vector;
        wait_reg <= 4'h0;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** prioritized_vectored_irq_ctrl_tb_top.sv ***
// Self-checking bench for the vectored interrupt controller.
// Assumes pvic_core and the core model pvic_cpu_model.
`timescale 1ns/10ps
`default_nettype none
`include "pvic_cfg.svh"
module prioritized_vectored_irq_ctrl_tb_top;
  logic clock_i, sys_rst_i, nmi, psel, penable, pwrite, ret, ack, ext, pready, pslverr;
  logic inh, tk, err_bit;
  logic [153:0] irq;
  logic [31:0] paddr, pwdata, prdata, rd, vt, tk_vec;
  logic [7:0] tk_id;
  logic [3:0] dly;
  pvic_pkg::pvic_entry_t entry;
  int err_count, comparisons, lat;
  pvic_core uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .irq_i(irq), .nmi_i(nmi),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .entry_ack_i(ack), .exit_i(ext), .entry_o(entry), .in_handler_o(inh));
  pvic_cpu_model cpu (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .entry_i(entry),
    .ack_dly_i(dly), .ret_i(ret), .entry_ack_o(ack), .exit_o(ext), .taken_o(tk),
    .taken_id_o(tk_id), .taken_vec_o(tk_vec));
  // 200 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // One APB transfer; waits for pready rather than assuming the wait state
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: apb answer missing", $time);
    end
    rd = prdata;
    err_bit = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic src(input int s, input logic [7:0] p);
    apb(1'b1, `PVIC_ADDR_ENABLE + 32'(4 * s), 32'h0000_0001);
    apb(1'b1, `PVIC_ADDR_PRIO + 32'(4 * s), {24'h0, p});
  endtask
  // Bit 154 of the mask is the non-maskable line
  task automatic pulse(input logic [154:0] m);
    @(posedge clock_i);
    {nmi, irq} <= m;
    @(posedge clock_i);
    {nmi, irq} <= 155'h0;
  endtask
  task automatic leave;
    @(posedge clock_i);
    ret <= 1'b1;
    @(posedge clock_i);
    ret <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask
  function automatic logic [31:0] vof(input int id);
    return vt + 32'(4 * (id + 16));
  endfunction
  task automatic take(input logic [7:0] id, input logic [31:0] vec);
    lat = 0;
    do begin
      @(posedge clock_i);
      lat++;
    end while (tk !== 1'b1 && lat < 200);
    chk({31'h0, tk}, 32'h1, "no entry");
    chk({24'h0, tk_id}, {24'h0, id}, "entry id");
    chk(tk_vec, vec, "entry vector");
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clock_i);
      chk({31'h0, tk}, 32'h0, "unexpected entry");
    end
  endtask
  task automatic t_regs;
    apb(1'b0, `PVIC_ADDR_PRIO + 32'h0000_0014, 32'h0);
    chk(rd, 32'h0, "prio reset");
    apb(1'b1, `PVIC_ADDR_PRIO + 32'h0000_0014, 32'h0000_00FF);
    apb(1'b0, `PVIC_ADDR_PRIO + 32'h0000_0014, 32'h0);
    chk(rd, 32'h0000_00E0, "prio low bits");
    apb(1'b0, 32'h0000_0FF0, 32'h0);
    chk({31'h0, err_bit}, 32'h1, "unmapped access");
    apb(1'b1, `PVIC_ADDR_VTOR, 32'h0000_07FF);
    apb(1'b0, `PVIC_ADDR_VTOR, 32'h0);
    chk(rd, 32'h0000_0400, "table base align");
    vt = 32'h0000_0400;
  endtask
  // Masked burst, NMI under mask, then priority and number order
  task automatic t_order;
    dly = 4'h3;
    apb(1'b1, `PVIC_ADDR_CTRL, 32'h0000_0001);
    src(10, 8'h40);
    src(3, 8'h40);
    src(7, 8'h20);
    pulse((155'h1 << 20) | (155'h1 << 10) | (155'h1 << 7) | (155'h1 << 3));
    quiet(30);
    pulse(155'h1 << 154);
    take(8'hFF, vt + 32'h0000_0008);
    leave;
    apb(1'b0, `PVIC_ADDR_PEND + 32'h0000_000C, 32'h0);
    chk(rd & 32'h1, 32'h1, "held pending");
    apb(1'b1, `PVIC_ADDR_CTRL, 32'h0);
    take(8'd7, vof(7));
    leave;
    take(8'd3, vof(3));
    apb(1'b0, `PVIC_ADDR_PEND + 32'h0000_000C, 32'h0);
    chk(rd & 32'h1, 32'h0, "pending cleared");
    leave;
    take(8'd10, vof(10));
    leave;
    quiet(20);
    chk({31'h0, inh}, 32'h0, "context left");
  endtask
  // Preemption with no sub-priority, then tail chaining with two sub bits
  task automatic t_nest;
    dly = 4'h0;
    src(30, 8'h40);
    src(31, 8'h20);
    pulse(155'h1 << 30);
    take(8'd30, vof(30));
    pulse(155'h1 << 31);
    take(8'd31, vof(31));
    leave;
    chk({31'h0, inh}, 32'h1, "still nested");
    leave;
    chk({31'h0, inh}, 32'h0, "nesting done");
    apb(1'b1, `PVIC_ADDR_CTRL, 32'h0000_0200);
    pulse(155'h1 << 30);
    take(8'd30, vof(30));
    pulse(155'h1 << 31);
    quiet(30);
    leave;
    take(8'd31, vof(31));
    leave;
  endtask
  task automatic t_table;
    int c;
    src(40, 8'h00);
    pulse(155'h1 << 40);
    take(8'd40, vof(40));
    c = lat;
    leave;
    vt = `PVIC_SRAM_BASE;
    apb(1'b1, `PVIC_ADDR_VTOR, vt);
    pulse(155'h1 << 40);
    take(8'd40, vof(40));
    chk(32'(lat - c), `PVIC_FETCH_CYC, "sram fetch delay");
    leave;
    // Highest source number, still inside the 256-word register region
    src(153, 8'hE0);
    pulse(155'h1 << 153);
    take(8'd153, vof(153));
    leave;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence; inputs idle at time zero, reset for 16 cycles
  initial begin
    {nmi, irq} = 155'h0;
    {psel, penable, pwrite, ret} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    dly = 4'h0;
    vt = 32'h0;
    sys_rst_i = 1'b1;
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_regs;
    t_order;
    t_nest;
    t_table;
    end_of_test;
  end
  // Whole run needs well under 1000 cycles; cut a hang at 20000
  initial begin
    #100000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test;
  end
endmodule
`default_nettype wire
